//--- design/rate_event_defines.svh
// Register offsets, field positions and reset values of the rate event generator.
`ifndef RATE_EVENT_DEFINES_SVH
`define RATE_EVENT_DEFINES_SVH

`define RATE_EVENT_CONFIG_ADDR       8'h30
`define PITCH_THRESHOLD_HIGH_ADDR    8'h31
`define PITCH_THRESHOLD_LOW_ADDR     8'h32
`define ROLL_THRESHOLD_HIGH_ADDR     8'h33
`define ROLL_THRESHOLD_LOW_ADDR      8'h34
`define YAW_THRESHOLD_HIGH_ADDR      8'h35
`define YAW_THRESHOLD_LOW_ADDR       8'h36
`define RATE_EVENT_DURATION_ADDR     8'h37
`define RATE_EVENT_SOURCE_ADDR       8'h38
`define RATE_EVENT_STATUS_ADDR       8'h39

`define REG_RESET                    8'h00
`define CFG_COMBINE_AND_BIT          7
`define CFG_LATCH_BIT                6
`define THS_DECREMENT_BIT            7
`define DUR_WAIT_BIT                 7
`define STATUS_FLAG_BIT              1
`define SRC_ACTIVE_BIT               6

`endif

//--- design/rate_event_pkg.sv
// Types shared by the rate event generator.
package rate_event_pkg;

	typedef logic [7:0]  byte_t;
	typedef logic [15:0] sample_t;
	typedef logic [14:0] threshold_t;
	typedef logic [6:0]  count_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_EXIT   = 2'b11
	} event_state_t;

endpackage

//--- design/rate_threshold_event_gen.sv
// Angular-rate threshold event generator with its byte register file.
//
// How it works
// - Enabled axis events are ORed when combine bit is 0, ANDed when 1.
// - Latch bit 1 holds an asserted request; bit 0 request follows the condition.
// - Enabled high event fires when the axis rate exceeds its threshold.
// - Enabled low event fires when the axis rate is below its threshold.
// - Six separate enables, high and low per axis; cleared enable suppresses event.
// - Thresholds are 15-bit two's complement, compared with same-axis samples.
// - Pitch threshold upper byte holds bits 14:8 plus counter-mode bit on top.
// - Lapsed condition resets the counter in mode 0, decrements it in mode 1.
// - Roll threshold is 15 bits split over an upper and lower byte.
// - Yaw threshold is 15 bits split over an upper and lower byte.
// - An event is recognised only after persisting the programmed duration samples.
// - The duration counter steps once per output sample.
// - Wait bit 0 drops the request as soon as the condition lapses.
// - Wait bit 1 holds the request until the lapse has persisted duration samples.
// - All configuration fields reset to zero.
// - Status flag reads 1 while a rate event request is present.
`timescale 1ns/1ps
`default_nettype none
`include "rate_event_defines.svh"

module rate_threshold_event_gen (
	input  wire logic                    clock,
	input  wire logic                    reset,
	input  wire logic                    clock_en,
	input  wire logic                    sample_valid,
	input  wire rate_event_pkg::sample_t pitch_sample,
	input  wire rate_event_pkg::sample_t roll_sample,
	input  wire rate_event_pkg::sample_t yaw_sample,
	input  wire logic [7:0]              reg_addr,
	input  wire rate_event_pkg::byte_t   reg_wdata,
	input  wire logic                    reg_write,
	input  wire logic                    reg_read,
	output logic [7:0]                   reg_rdata,
	output logic                         rate_event_request
);
	import rate_event_pkg::*;

	// Index 0 pitch, 1 roll, 2 yaw.
	byte_t        cfg_ff;
	byte_t        ths_high_ff [3];
	byte_t        ths_low_ff  [3];
	byte_t        dur_ff;
	logic [5:0]   src_ff;
	count_t       count_ff;
	count_t       nxt_count;
	event_state_t state_ff;
	event_state_t nxt_state;
	logic         request_ff;
	logic         nxt_request;
	logic         latched_ff;
	byte_t        rdata_ff;
	byte_t        nxt_rdata;

	sample_t      samples [3];
	logic [5:0]   axis_event;
	logic [5:0]   enables;

	assign samples[0] = pitch_sample;
	assign samples[1] = roll_sample;
	assign samples[2] = yaw_sample;

	// Sign-extend a 15-bit threshold to sample width for a signed compare.
	function automatic sample_t threshold_of(input byte_t hi, input byte_t lo);
		threshold_t t;
		t = {hi[6:0], lo};
		return {t[14], t};
	endfunction

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_axis
			wire sample_t ths = threshold_of(ths_high_ff[g], ths_low_ff[g]);
			assign axis_event[2*g+1] = $signed(samples[g]) > $signed(ths);
			assign axis_event[2*g]   = $signed(samples[g]) < $signed(ths);
		end
	endgenerate

	assign enables = cfg_ff[5:0];

	wire logic [5:0] masked   = axis_event & enables;
	wire logic       any_en   = |enables;
	wire logic       comb_or  = |masked;
	wire logic       comb_and = any_en && (masked == enables);
	wire logic       condition = cfg_ff[`CFG_COMBINE_AND_BIT] ? comb_and : comb_or;
	wire count_t     duration  = dur_ff[6:0];
	wire logic       wait_en   = dur_ff[`DUR_WAIT_BIT];
	wire logic       decrement = ths_high_ff[0][`THS_DECREMENT_BIT];
	wire logic       latch_en  = cfg_ff[`CFG_LATCH_BIT];
	wire logic       step      = clock_en && sample_valid;

	wire logic       src_read  = reg_read && (reg_addr == `RATE_EVENT_SOURCE_ADDR);
	wire logic       request_o = request_ff || latched_ff;

	// Qualification state machine, advanced once per sample.
	always_comb begin
		nxt_state   = state_ff;
		nxt_count   = count_ff;
		nxt_request = request_ff;
		case (state_ff)
			ST_IDLE: begin
				if (condition) begin
					if (count_ff + 7'h01 >= duration || duration == 7'h00) begin
						nxt_state   = ST_ACTIVE;
						nxt_request = 1'b1;
						nxt_count   = 7'h00;
					end else begin
						nxt_count = count_ff + 7'h01;
					end
				end else if (decrement) begin
					nxt_count = (count_ff != 7'h00) ? count_ff - 7'h01 : 7'h00;
				end else begin
					nxt_count = 7'h00;
				end
			end
			ST_ACTIVE: begin
				if (!condition) begin
					if (wait_en && duration != 7'h00) begin
						nxt_state = ST_EXIT;
						nxt_count = 7'h01;
						if (duration == 7'h01) begin
							nxt_state   = ST_IDLE;
							nxt_request = 1'b0;
							nxt_count   = 7'h00;
						end
					end else begin
						nxt_state   = ST_IDLE;
						nxt_request = 1'b0;
						nxt_count   = 7'h00;
					end
				end
			end
			ST_EXIT: begin
				if (condition) begin
					nxt_state = ST_ACTIVE;
					nxt_count = 7'h00;
				end else if (count_ff + 7'h01 >= duration) begin
					nxt_state   = ST_IDLE;
					nxt_request = 1'b0;
					nxt_count   = 7'h00;
				end else begin
					nxt_count = count_ff + 7'h01;
				end
			end
			default: begin
				nxt_state   = ST_IDLE;
				nxt_request = 1'b0;
				nxt_count   = 7'h00;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_ff   <= ST_IDLE;
			count_ff   <= 7'h00;
			request_ff <= 1'b0;
		end else if (step) begin
			state_ff   <= nxt_state;
			count_ff   <= nxt_count;
			request_ff <= nxt_request;
		end
	end

	// A new event in the same cycle as the clearing read wins over the clear.
	wire logic rise   = step && nxt_request && !request_ff;
	wire logic [5:0] src_new = step && nxt_request ? masked : 6'h00;

	always_ff @(posedge clock) begin
		if (reset) begin
			latched_ff <= 1'b0;
			src_ff     <= 6'h00;
		end else if (clock_en) begin
			if (rise && latch_en) begin
				latched_ff <= 1'b1;
			end else if (src_read || !latch_en) begin
				latched_ff <= 1'b0;
			end
			if (src_new != 6'h00) begin
				src_ff <= src_read ? src_new : (src_ff | src_new);
			end else if (src_read) begin
				src_ff <= 6'h00;
			end
		end
	end

	assign rate_event_request = request_o;

	// Register file.
	always_ff @(posedge clock) begin
		if (reset) begin
			cfg_ff <= `REG_RESET;
			dur_ff <= `REG_RESET;
			for (int i = 0; i < 3; i++) begin
				ths_high_ff[i] <= `REG_RESET;
				ths_low_ff[i]  <= `REG_RESET;
			end
		end else if (clock_en && reg_write) begin
			case (reg_addr)
				`RATE_EVENT_CONFIG_ADDR:    cfg_ff         <= reg_wdata;
				`PITCH_THRESHOLD_HIGH_ADDR: ths_high_ff[0] <= reg_wdata;
				`PITCH_THRESHOLD_LOW_ADDR:  ths_low_ff[0]  <= reg_wdata;
				// Top bit is stored as written; the host keeps it zero.
				`ROLL_THRESHOLD_HIGH_ADDR:  ths_high_ff[1] <= reg_wdata;
				`ROLL_THRESHOLD_LOW_ADDR:   ths_low_ff[1]  <= reg_wdata;
				`YAW_THRESHOLD_HIGH_ADDR:   ths_high_ff[2] <= reg_wdata;
				`YAW_THRESHOLD_LOW_ADDR:    ths_low_ff[2]  <= reg_wdata;
				`RATE_EVENT_DURATION_ADDR:  dur_ff         <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		case (reg_addr)
			`RATE_EVENT_CONFIG_ADDR:    nxt_rdata = cfg_ff;
			`PITCH_THRESHOLD_HIGH_ADDR: nxt_rdata = ths_high_ff[0];
			`PITCH_THRESHOLD_LOW_ADDR:  nxt_rdata = ths_low_ff[0];
			`ROLL_THRESHOLD_HIGH_ADDR:  nxt_rdata = ths_high_ff[1];
			`ROLL_THRESHOLD_LOW_ADDR:   nxt_rdata = ths_low_ff[1];
			`YAW_THRESHOLD_HIGH_ADDR:   nxt_rdata = ths_high_ff[2];
			`YAW_THRESHOLD_LOW_ADDR:    nxt_rdata = ths_low_ff[2];
			`RATE_EVENT_DURATION_ADDR:  nxt_rdata = dur_ff;
			`RATE_EVENT_SOURCE_ADDR:    nxt_rdata = {1'b0, request_o, src_ff};
			`RATE_EVENT_STATUS_ADDR:    nxt_rdata = {6'h00, request_o, 1'b0};
			default:                    nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_ff <= 8'h00;
		end else if (clock_en) begin
			rdata_ff <= reg_read ? nxt_rdata : 8'h00;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

//--- testbench/rate_event_sva.sv
// Checker for the rate event generator ports.
`timescale 1ns/1ps
`default_nettype none
module rate_event_sva (
	input wire logic                  clock,
	input wire logic                  reset,
	input wire logic                  clock_en,
	input wire logic                  sample_valid,
	input wire logic [7:0]            reg_addr,
	input wire rate_event_pkg::byte_t reg_wdata,
	input wire logic                  reg_write,
	input wire logic                  reg_read,
	input wire logic [7:0]            reg_rdata,
	input wire logic                  rate_event_request
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence cfg_wr;
		clock_en && reg_write && reg_addr inside {[8'h30:8'h37]};
	endsequence
	sequence same_rd;
		clock_en && reg_read && reg_addr == $past(reg_addr, 2);
	endsequence
	rd_idle_a: assert property (clock_en && !reg_read |=> reg_rdata == 8'h00)
		else $error("stale read data");
	unmapped_rd_a: assert property (clock_en && reg_read &&
		!(reg_addr inside {[8'h30:8'h39]}) |=> reg_rdata == 8'h00) else $error("unmapped data");
	req_rise_a: assert property ($rose(rate_event_request)
		|-> $past(clock_en && sample_valid)) else $error("rise without sample");
	req_fall_a: assert property ($fell(rate_event_request)
		|-> $past(clock_en && (sample_valid || reg_read)) || $past(reg_write, 2))
		else $error("stray fall");
	freeze_a: assert property (!clock_en |=> $stable(rate_event_request)
		&& $stable(reg_rdata)) else $error("moved while frozen");
	cfg_readback_a: assert property (cfg_wr ##1 clock_en && !reg_write ##1 same_rd
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("readback differs");
	status_flag_a: assert property (clock_en && reg_read && reg_addr == 8'h39
		|=> reg_rdata[1] == $past(rate_event_request)) else $error("flag differs");
	source_active_a: assert property (clock_en && reg_read && reg_addr == 8'h38
		|=> reg_rdata[6] == $past(rate_event_request)) else $error("source differs");
endmodule
bind rate_threshold_event_gen rate_event_sva chk_u (.clock(clock), .reset(reset),
	.clock_en(clock_en), .sample_valid(sample_valid), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .rate_event_request(rate_event_request));
`default_nettype wire

//--- testbench/rate_sample_source.sv
// Behavioural source of three-axis rate samples.
`timescale 1ns/1ps
`default_nettype none
module rate_sample_source (
	input  wire logic             clock,
	input  wire logic             fire,
	input  wire logic [47:0]      next_set,
	output logic                  sample_valid,
	output rate_event_pkg::sample_t pitch_sample,
	output rate_event_pkg::sample_t roll_sample,
	output rate_event_pkg::sample_t yaw_sample
);
	import rate_event_pkg::*;
	// Off the valid pulse the lines flip each cycle, so stale data looks right only on alternate cycles.
	always_ff @(posedge clock) begin
		sample_valid <= fire;
		{pitch_sample, roll_sample, yaw_sample} <= fire ? next_set
			: ~{pitch_sample, roll_sample, yaw_sample};
	end
endmodule
`default_nettype wire

//--- testbench/rate_threshold_event_gen_tb.sv
// Self-checking bench for the rate event generator.
`timescale 1ns/1ps
`default_nettype none
module rate_threshold_event_gen_tb;
	import rate_event_pkg::*;
	logic        clock, reset, clock_en, fire, sample_valid;
	logic        reg_write, reg_read, rate_event_request;
	logic [47:0] next_set;
	sample_t     pitch_sample, roll_sample, yaw_sample;
	logic [7:0]  reg_addr, reg_rdata;
	byte_t       reg_wdata;
	int          miscompares, samples_checked;
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	rate_sample_source src_u (.clock(clock), .fire(fire), .next_set(next_set),
		.sample_valid(sample_valid), .pitch_sample(pitch_sample),
		.roll_sample(roll_sample), .yaw_sample(yaw_sample));
	rate_threshold_event_gen dut_u (.clock(clock), .reset(reset), .clock_en(clock_en),
		.sample_valid(sample_valid), .pitch_sample(pitch_sample),
		.roll_sample(roll_sample), .yaw_sample(yaw_sample), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .rate_event_request(rate_event_request));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want) begin
			miscompares++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [7:0] a, input byte_t d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, want);
	endtask
	// The extra edge lets the request settle whichever cycle it updates in.
	task automatic smp(input sample_t p, input sample_t r, input sample_t y, input logic want);
		@(posedge clock);
		fire <= 1'b1;
		next_set <= {p, r, y};
		@(posedge clock);
		fire <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk({7'h00, rate_event_request}, {7'h00, want});
	endtask
	task automatic t_reset;
		for (logic [7:0] a = 8'h30; a < 8'h38; a++)
			rd(a, 8'h00);
		rd(8'h3A, 8'h00);
		wr(8'h31, 8'h7F);
		rd(8'h31, 8'h7F);
	endtask
	task automatic t_threshold;
		wr(8'h32, 8'hFE);
		wr(8'h30, 8'h01);
		smp(16'hFFFE, '0, '0, 1'b0);
		smp(16'hFFFD, '0, '0, 1'b1);
		wr(8'h30, 8'h00);
		smp(16'hFFFD, '0, '0, 1'b0);
		wr(8'h31, 8'h00);
		wr(8'h32, 8'h00);
	endtask
	task automatic t_or_and;
		wr(8'h34, 8'h10);
		wr(8'h35, 8'h01);
		wr(8'h30, 8'h28);
		smp('0, 16'h0010, '0, 1'b0);
		smp('0, 16'h0011, '0, 1'b1);
		smp('0, '0, 16'h0100, 1'b0);
		smp('0, '0, 16'h0101, 1'b1);
		wr(8'h30, 8'hA8);
		smp('0, 16'h0011, '0, 1'b0);
		smp('0, 16'h0011, 16'h0101, 1'b1);
		// Let the request fall before the next scenario reuses the machine.
		smp('0, '0, '0, 1'b0);
		wr(8'h30, 8'h02);
		wr(8'h34, 8'h00);
		wr(8'h35, 8'h00);
	endtask
	task automatic t_duration;
		logic [7:0] pat;
		pat = 8'hD8;
		wr(8'h37, 8'h03);
		smp(16'h0005, '0, '0, 1'b0);
		smp(16'h0005, '0, '0, 1'b0);
		smp(16'h0005, '0, '0, 1'b1);
		wr(8'h37, 8'h83);
		smp('0, '0, '0, 1'b1);
		smp('0, '0, '0, 1'b1);
		smp('0, '0, '0, 1'b0);
		wr(8'h31, 8'h80);
		for (int i = 0; i < 8; i++)
			smp(pat[i] ? 16'h0005 : 16'h0000, '0, '0, i == 7);
		wr(8'h31, 8'h00);
		wr(8'h37, 8'h00);
	endtask
	task automatic t_latch;
		// Events gathered so far: pitch low and high, roll high, yaw high; request active.
		rd(8'h38, 8'h6B);
		wr(8'h30, 8'h42);
		smp('0, '0, '0, 1'b0);
		smp(16'h0005, '0, '0, 1'b1);
		smp('0, '0, '0, 1'b1);
		@(posedge clock);
		clock_en <= 1'b0;
		repeat (3) @(posedge clock);
		clock_en <= 1'b1;
		rd(8'h39, 8'h02);
		rd(8'h38, 8'h42);
		@(posedge clock);
		#1 chk({7'h00, rate_event_request}, 8'h00);
	endtask
	initial begin
		{reset, clock_en} = 2'b11;
		{fire, reg_write, reg_read} = 3'b000;
		next_set = '0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		miscompares = 0;
		samples_checked = 0;
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		t_reset;
		t_threshold;
		t_or_and;
		t_duration;
		t_latch;
		report_and_stop;
	end
	initial begin
		#100000;
		miscompares++;
		report_and_stop;
	end
endmodule
`default_nettype wire
